// ==== src/mect_pkg.sv ====
package mect_pkg;
  // ****************************************
  // Register map and field layout
  // ****************************************
  localparam logic [11:0] MECT_IC_CNT_ADDR = 12'h7f0;
  localparam int MECT_CNT_W = 27;
  localparam int MECT_THR_W = 5;
  localparam int MECT_CNT_LSB = 0;
  localparam int MECT_THR_LSB = 27;
  localparam logic [4:0] MECT_THR_MAX = 5'h1a;
  localparam logic [26:0] MECT_CNT_RST = 27'h0;
  localparam logic [4:0] MECT_THR_RST = 5'h0;

  // ****************************************
  // Memory word geometry
  // ****************************************
  localparam int MECT_DATA_W = 32;
  localparam int MECT_ECC_W = 7;
  localparam int MECT_HAM_W = 6;
  localparam int MECT_CW_N = 38;
  localparam int MECT_ADDR_W = 16;
  localparam int MECT_IC_WAYS = 4;

  typedef enum logic [1:0] {ACC_LOAD, ACC_STORE, ACC_DMA, ACC_FETCH} mect_kind_t;

  typedef struct packed {
    logic valid;
    mect_kind_t kind;
    logic retire;
    logic nonspec;
    logic [MECT_ADDR_W-1:0] addr;
    logic [MECT_DATA_W-1:0] data;
    logic [MECT_ECC_W-1:0] ecc;
  } mect_data_tightly_coupled_memory_req_t;

  typedef struct packed {
    logic valid;
    logic [MECT_ADDR_W-1:0] addr;
    logic [MECT_DATA_W-1:0] data;
    logic [MECT_ECC_W-1:0] ecc;
  } mect_fetch_t;

  typedef struct packed {
    logic en;
    logic [MECT_ADDR_W-1:0] addr;
    logic [MECT_DATA_W-1:0] data;
    logic [MECT_ECC_W-1:0] ecc;
  } mect_wb_t;

  typedef struct packed {
    logic valid;
    mect_kind_t kind;
    logic err;
  } mect_sys_t;

  typedef struct packed {
    logic we;
    logic [11:0] addr;
    logic [31:0] wdata;
  } mect_csr_t;

  typedef struct packed {
    logic [MECT_DATA_W-1:0] data;
    logic [MECT_ECC_W-1:0] ecc;
    logic single;
    logic double;
  } mect_dec_t;

  typedef struct packed {
    logic [MECT_CNT_W-1:0] count;
    logic [MECT_THR_W-1:0] thresh;
    mect_wb_t data_tightly_coupled_memory_wb;
    mect_wb_t instruction_tightly_coupled_memory_wb;
    logic [MECT_DATA_W-1:0] data_tightly_coupled_memory_data;
    logic data_tightly_coupled_memory_data_valid;
    logic data_tightly_coupled_memory_sb;
    logic instruction_tightly_coupled_memory_sb;
    logic load_fault;
    logic store_fault;
    logic dma_err;
    logic instr_fault;
    logic store_nmi;
    logic refetch;
    logic sys_ok;
  } mect_state_t;
endpackage

// ==== src/mect_top.sv ====
`timescale 1ns/100ps
// Summary of operation
// - Each data memory word has 32 data bits and 7 check bits, checked per access.
// - Data memory single-bit error is corrected in-line and written back.
// - Load/store write-back and counting happen only when the instruction retires.
// - Data memory double-bit error: load fault, store fault, or DMA error response.
// - Double-bit faults for loads and stores are raised only for non-speculative access.
// - Several cache errors in one cycle add only one to the count.
// - Cache errors and instruction memory single-bit errors recover by flush and refetch.
// - Every instruction memory fetch single-bit error is corrected, written back, counted.
// - No address of a correctable error is kept, only counts.
// - Counter register takes any write and always reads a legal value.
// - Count increments on tag or data error in the cache.
// - Threshold selects a count bit; its rise signals the local interrupt.
// - Interrupt is a level that holds while the selected bit stays set.
// - Firmware reset of the counter clears the pending interrupt condition.
// - Threshold above 26 is stored as 26.
// - Reads leave the register unchanged; writes update both fields together.
// - Count wraps with no saturation.
// - Counter register sits at control register address 0x7f0.
// - Interrupt reaches software only when enabled.
module mect_top (
  input wire logic MCLK,
  input wire logic RST,
  input mect_pkg::mect_csr_t CSR,
  output logic CSR_HIT,
  output logic [31:0] CSR_RDATA,
  input mect_pkg::mect_data_tightly_coupled_memory_req_t DATA_TIGHTLY_COUPLED_MEMORY_REQ,
  output logic [mect_pkg::MECT_DATA_W-1:0] DATA_TIGHTLY_COUPLED_MEMORY_DATA,
  output logic DATA_TIGHTLY_COUPLED_MEMORY_DATA_VALID,
  output mect_pkg::mect_wb_t DATA_TIGHTLY_COUPLED_MEMORY_WB,
  output logic DATA_TIGHTLY_COUPLED_MEMORY_SB_COUNT,
  input mect_pkg::mect_fetch_t INSTRUCTION_TIGHTLY_COUPLED_MEMORY_FETCH,
  output mect_pkg::mect_wb_t INSTRUCTION_TIGHTLY_COUPLED_MEMORY_WB,
  output logic INSTRUCTION_TIGHTLY_COUPLED_MEMORY_SB_COUNT,
  input wire logic [mect_pkg::MECT_IC_WAYS-1:0] IC_TAG_ERR,
  input wire logic [mect_pkg::MECT_IC_WAYS-1:0] IC_DATA_ERR,
  input mect_pkg::mect_sys_t SYS_RESP,
  output logic SYS_DATA_OK,
  output logic REFETCH_PC_FLUSH,
  output logic INSTR_ACCESS_FAULT,
  output logic LOAD_ACCESS_FAULT,
  output logic STORE_ACCESS_FAULT,
  output logic STORE_BUS_NMI,
  output logic DMA_ERR_RESP,
  input wire logic CE_INT_EN,
  output logic CE_INT
);
  import mect_pkg::*;

  // ****************************************
  // SECDED code over 38 positions
  // ****************************************
  function automatic logic [MECT_ECC_W-1:0] ecc_gen(input logic [MECT_DATA_W-1:0] d);
    logic [MECT_CW_N:1] cw;
    logic [MECT_ECC_W-1:0] p;
    int j;
    cw = '0;
    p = '0;
    j = 0;
    for (int pos = 1; pos <= MECT_CW_N; pos++) begin
      if ((pos & (pos - 1)) != 0) begin
        cw[pos] = d[j];
        j++;
      end
    end
    for (int i = 0; i < MECT_HAM_W; i++) begin
      for (int pos = 1; pos <= MECT_CW_N; pos++) begin
        if (pos[i]) p[i] = p[i] ^ cw[pos];
      end
    end
    // Overall bit makes the whole word even, so odd parity means one flip
    p[MECT_HAM_W] = (^cw) ^ (^p[MECT_HAM_W-1:0]);
    return p;
  endfunction

  function automatic mect_dec_t ecc_check(input logic [MECT_DATA_W-1:0] d,
                                          input logic [MECT_ECC_W-1:0] e);
    mect_dec_t r;
    logic [MECT_HAM_W-1:0] syn;
    logic odd;
    logic [MECT_ECC_W-1:0] gen;
    int j;
    // Select on a call result is not portable; work on a copy
    gen = ecc_gen(d);
    syn = e[MECT_HAM_W-1:0] ^ gen[MECT_HAM_W-1:0];
    odd = ^{d, e};
    r.data = d;
    j = 0;
    for (int pos = 1; pos <= MECT_CW_N; pos++) begin
      if ((pos & (pos - 1)) != 0) begin
        if (odd && syn == pos[MECT_HAM_W-1:0]) r.data[j] = ~d[j];
        j++;
      end
    end
    r.ecc = ecc_gen(r.data);
    r.single = odd;
    r.double = !odd && (syn != '0);
    return r;
  endfunction

  mect_state_t st;
  mect_state_t next_st;
  mect_dec_t data_tightly_coupled_memory_dec;
  mect_dec_t instruction_tightly_coupled_memory_dec;
  logic csr_sel;
  logic csr_wr;
  logic ic_err;
  logic [MECT_CNT_W-1:0] base_cnt;
  logic [MECT_THR_W-1:0] wr_thr;

  assign data_tightly_coupled_memory_dec = ecc_check(DATA_TIGHTLY_COUPLED_MEMORY_REQ.data, DATA_TIGHTLY_COUPLED_MEMORY_REQ.ecc);
  assign instruction_tightly_coupled_memory_dec = ecc_check(INSTRUCTION_TIGHTLY_COUPLED_MEMORY_FETCH.data, INSTRUCTION_TIGHTLY_COUPLED_MEMORY_FETCH.ecc);
  assign csr_sel = (CSR.addr == MECT_IC_CNT_ADDR);
  assign csr_wr = CSR.we && csr_sel;
  // Many ways flagging at once still counts as one event
  assign ic_err = (|IC_TAG_ERR) || (|IC_DATA_ERR);
  assign wr_thr = CSR.wdata[MECT_THR_LSB +: MECT_THR_W];

  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb begin
    next_st = st;
    next_st.data_tightly_coupled_memory_wb.en = 1'b0;
    next_st.instruction_tightly_coupled_memory_wb.en = 1'b0;
    next_st.data_tightly_coupled_memory_data_valid = 1'b0;
    next_st.data_tightly_coupled_memory_sb = 1'b0;
    next_st.instruction_tightly_coupled_memory_sb = 1'b0;
    next_st.load_fault = 1'b0;
    next_st.store_fault = 1'b0;
    next_st.dma_err = 1'b0;
    next_st.instr_fault = 1'b0;
    next_st.store_nmi = 1'b0;
    next_st.refetch = 1'b0;
    next_st.sys_ok = 1'b0;

    // Write and error in the same cycle: the error is added to the written count
    base_cnt = csr_wr ? CSR.wdata[MECT_CNT_LSB +: MECT_CNT_W] : st.count;
    next_st.count = base_cnt + MECT_CNT_W'(ic_err);
    if (csr_wr) begin
      next_st.thresh = (wr_thr > MECT_THR_MAX) ? MECT_THR_MAX : wr_thr;
    end

    if (DATA_TIGHTLY_COUPLED_MEMORY_REQ.valid) begin
      next_st.data_tightly_coupled_memory_data = data_tightly_coupled_memory_dec.data;
      next_st.data_tightly_coupled_memory_data_valid = !data_tightly_coupled_memory_dec.double;
      next_st.data_tightly_coupled_memory_wb.addr = DATA_TIGHTLY_COUPLED_MEMORY_REQ.addr;
      next_st.data_tightly_coupled_memory_wb.data = data_tightly_coupled_memory_dec.data;
      next_st.data_tightly_coupled_memory_wb.ecc = data_tightly_coupled_memory_dec.ecc;
      if (data_tightly_coupled_memory_dec.single && (DATA_TIGHTLY_COUPLED_MEMORY_REQ.kind == ACC_DMA || DATA_TIGHTLY_COUPLED_MEMORY_REQ.retire)) begin
        next_st.data_tightly_coupled_memory_wb.en = 1'b1;
        next_st.data_tightly_coupled_memory_sb = 1'b1;
      end
      if (data_tightly_coupled_memory_dec.double) begin
        unique case (DATA_TIGHTLY_COUPLED_MEMORY_REQ.kind)
          ACC_LOAD: next_st.load_fault = DATA_TIGHTLY_COUPLED_MEMORY_REQ.nonspec;
          ACC_STORE: next_st.store_fault = DATA_TIGHTLY_COUPLED_MEMORY_REQ.nonspec;
          ACC_DMA: next_st.dma_err = 1'b1;
          ACC_FETCH: next_st.dma_err = 1'b0;
        endcase
      end
    end

    // Fetch data is never patched in-line; correction reaches the core by refetch
    if (INSTRUCTION_TIGHTLY_COUPLED_MEMORY_FETCH.valid) begin
      next_st.instruction_tightly_coupled_memory_wb.addr = INSTRUCTION_TIGHTLY_COUPLED_MEMORY_FETCH.addr;
      next_st.instruction_tightly_coupled_memory_wb.data = instruction_tightly_coupled_memory_dec.data;
      next_st.instruction_tightly_coupled_memory_wb.ecc = instruction_tightly_coupled_memory_dec.ecc;
      next_st.instruction_tightly_coupled_memory_wb.en = instruction_tightly_coupled_memory_dec.single;
      next_st.instruction_tightly_coupled_memory_sb = instruction_tightly_coupled_memory_dec.single;
      next_st.instr_fault = instruction_tightly_coupled_memory_dec.double;
    end
    next_st.refetch = ic_err || (INSTRUCTION_TIGHTLY_COUPLED_MEMORY_FETCH.valid && instruction_tightly_coupled_memory_dec.single);

    if (SYS_RESP.valid) begin
      next_st.sys_ok = !SYS_RESP.err;
      if (SYS_RESP.err) begin
        unique case (SYS_RESP.kind)
          ACC_FETCH: next_st.instr_fault = 1'b1;
          ACC_LOAD: next_st.load_fault = 1'b1;
          ACC_STORE: next_st.store_nmi = 1'b1;
          ACC_DMA: next_st.store_nmi = 1'b0;
        endcase
      end
    end
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      st <= '0;
      st.count <= MECT_CNT_RST;
      st.thresh <= MECT_THR_RST;
    end else begin
      st <= next_st;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign CSR_HIT = csr_sel;
  assign CSR_RDATA = csr_sel ? {st.thresh, st.count} : 32'h0;
  // Level, not latched: a fast error stream can pass the bit before software looks
  assign CE_INT = CE_INT_EN && st.count[st.thresh];
  assign DATA_TIGHTLY_COUPLED_MEMORY_DATA = st.data_tightly_coupled_memory_data;
  assign DATA_TIGHTLY_COUPLED_MEMORY_DATA_VALID = st.data_tightly_coupled_memory_data_valid;
  assign DATA_TIGHTLY_COUPLED_MEMORY_WB = st.data_tightly_coupled_memory_wb;
  assign DATA_TIGHTLY_COUPLED_MEMORY_SB_COUNT = st.data_tightly_coupled_memory_sb;
  assign INSTRUCTION_TIGHTLY_COUPLED_MEMORY_WB = st.instruction_tightly_coupled_memory_wb;
  assign INSTRUCTION_TIGHTLY_COUPLED_MEMORY_SB_COUNT = st.instruction_tightly_coupled_memory_sb;
  assign SYS_DATA_OK = st.sys_ok;
  assign REFETCH_PC_FLUSH = st.refetch;
  assign INSTR_ACCESS_FAULT = st.instr_fault;
  assign LOAD_ACCESS_FAULT = st.load_fault;
  assign STORE_ACCESS_FAULT = st.store_fault;
  assign STORE_BUS_NMI = st.store_nmi;
  assign DMA_ERR_RESP = st.dma_err;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);

  count_step_a: assert property (!csr_wr && ic_err |=> st.count == $past(st.count) + 27'h1)
    else $error("count did not step by one");
  count_hold_a: assert property (!csr_wr && !ic_err |=> $stable(st.count) && $stable(st.thresh))
    else $error("register changed without cause");
  thresh_clamp_a: assert property (csr_wr && wr_thr > 5'h1a |=> st.thresh == 5'h1a)
    else $error("threshold not clamped");
  thresh_legal_a: assert property (st.thresh <= 5'h1a)
    else $error("illegal threshold held");
  int_level_a: assert property (CE_INT == (CE_INT_EN && st.count[st.thresh]))
    else $error("interrupt level wrong");
  write_clear_a: assert property (csr_wr && CSR.wdata[26:0] == 27'h0 && !ic_err |=> !CE_INT)
    else $error("reset of counter left interrupt");
  data_tightly_coupled_memory_retire_a: assert property (DATA_TIGHTLY_COUPLED_MEMORY_REQ.valid && data_tightly_coupled_memory_dec.single
      && DATA_TIGHTLY_COUPLED_MEMORY_REQ.kind != ACC_DMA && !DATA_TIGHTLY_COUPLED_MEMORY_REQ.retire |=> !DATA_TIGHTLY_COUPLED_MEMORY_WB.en && !DATA_TIGHTLY_COUPLED_MEMORY_SB_COUNT)
    else $error("speculative write-back");
  data_tightly_coupled_memory_fix_a: assert property (DATA_TIGHTLY_COUPLED_MEMORY_REQ.valid && data_tightly_coupled_memory_dec.single && DATA_TIGHTLY_COUPLED_MEMORY_REQ.retire
      |=> DATA_TIGHTLY_COUPLED_MEMORY_WB.en && DATA_TIGHTLY_COUPLED_MEMORY_WB.ecc == ecc_gen(DATA_TIGHTLY_COUPLED_MEMORY_WB.data))
    else $error("bad corrected write-back");
  spec_fault_a: assert property (DATA_TIGHTLY_COUPLED_MEMORY_REQ.valid && data_tightly_coupled_memory_dec.double
      && DATA_TIGHTLY_COUPLED_MEMORY_REQ.kind == ACC_STORE && !DATA_TIGHTLY_COUPLED_MEMORY_REQ.nonspec && !(SYS_RESP.valid && SYS_RESP.err)
      |=> !STORE_ACCESS_FAULT)
    else $error("speculative store fault");
  instruction_tightly_coupled_memory_count_a: assert property (INSTRUCTION_TIGHTLY_COUPLED_MEMORY_FETCH.valid && instruction_tightly_coupled_memory_dec.single
      |=> INSTRUCTION_TIGHTLY_COUPLED_MEMORY_WB.en && INSTRUCTION_TIGHTLY_COUPLED_MEMORY_SB_COUNT && REFETCH_PC_FLUSH)
    else $error("fetch error not handled");
  sys_nmi_a: assert property (SYS_RESP.valid && SYS_RESP.err
      && SYS_RESP.kind == ACC_STORE |=> STORE_BUS_NMI && !SYS_DATA_OK)
    else $error("store bus error missed");

  // ****************************************
  // Fault and register path checks
  // ****************************************
  cache_flush_a: assert property (ic_err |=> REFETCH_PC_FLUSH)
    else $error("cache error without flush");
  load_double_a: assert property (DATA_TIGHTLY_COUPLED_MEMORY_REQ.valid && data_tightly_coupled_memory_dec.double
      && DATA_TIGHTLY_COUPLED_MEMORY_REQ.kind == ACC_LOAD && DATA_TIGHTLY_COUPLED_MEMORY_REQ.nonspec |=> LOAD_ACCESS_FAULT && !DATA_TIGHTLY_COUPLED_MEMORY_DATA_VALID)
    else $error("load double error missed");
  dma_double_a: assert property (DATA_TIGHTLY_COUPLED_MEMORY_REQ.valid && data_tightly_coupled_memory_dec.double
      && DATA_TIGHTLY_COUPLED_MEMORY_REQ.kind == ACC_DMA |=> DMA_ERR_RESP && !DATA_TIGHTLY_COUPLED_MEMORY_DATA_VALID)
    else $error("dma double error missed");
  dma_single_a: assert property (DATA_TIGHTLY_COUPLED_MEMORY_REQ.valid && data_tightly_coupled_memory_dec.single
      && DATA_TIGHTLY_COUPLED_MEMORY_REQ.kind == ACC_DMA |=> DATA_TIGHTLY_COUPLED_MEMORY_WB.en && DATA_TIGHTLY_COUPLED_MEMORY_SB_COUNT && DATA_TIGHTLY_COUPLED_MEMORY_DATA_VALID)
    else $error("dma single error not fixed");
  wb_addr_a: assert property (DATA_TIGHTLY_COUPLED_MEMORY_REQ.valid |=> DATA_TIGHTLY_COUPLED_MEMORY_WB.addr == $past(DATA_TIGHTLY_COUPLED_MEMORY_REQ.addr))
    else $error("write-back to wrong word");
  // Fetched words are repaired at their own address only
  fetch_addr_a: assert property (INSTRUCTION_TIGHTLY_COUPLED_MEMORY_FETCH.valid
      |=> INSTRUCTION_TIGHTLY_COUPLED_MEMORY_WB.addr == $past(INSTRUCTION_TIGHTLY_COUPLED_MEMORY_FETCH.addr))
    else $error("fetch write-back to wrong word");
  write_take_a: assert property (csr_wr && !ic_err
      |=> st.count == $past(CSR.wdata[26:0]))
    else $error("written count not taken");
  // A write racing a cache error keeps the error on top of the new count
  set_wins_a: assert property (csr_wr && ic_err
      |=> st.count == $past(CSR.wdata[26:0]) + 27'h1)
    else $error("cache error lost to write");
  thresh_take_a: assert property (csr_wr && wr_thr <= 5'h1a
      |=> st.thresh == $past(wr_thr))
    else $error("legal threshold not taken");
  int_gate_a: assert property (!CE_INT_EN |-> !CE_INT)
    else $error("interrupt passed while disabled");
  int_hold_a: assert property (CE_INT && !csr_wr && !ic_err |=> CE_INT || !CE_INT_EN)
    else $error("interrupt dropped while bit set");
  reset_value_a: assert property ($fell(RST)
      |-> st.count == 27'h0 && st.thresh == 5'h0 && !CE_INT)
    else $error("register not empty after reset");
  sys_load_a: assert property (SYS_RESP.valid && SYS_RESP.err
      && SYS_RESP.kind == ACC_LOAD |=> LOAD_ACCESS_FAULT && !SYS_DATA_OK)
    else $error("system load error missed");
  sys_fetch_a: assert property (SYS_RESP.valid && SYS_RESP.err
      && SYS_RESP.kind == ACC_FETCH |=> INSTR_ACCESS_FAULT && !SYS_DATA_OK)
    else $error("system fetch error missed");
  sys_ok_a: assert property (SYS_RESP.valid && !SYS_RESP.err |=> SYS_DATA_OK)
    else $error("good system data refused");

  int_rise_c: cover property (!CE_INT ##1 CE_INT);
  wrap_c: cover property (st.count == 27'h7ffffff && ic_err && !csr_wr);
  data_tightly_coupled_memory_double_c: cover property (DATA_TIGHTLY_COUPLED_MEMORY_REQ.valid && data_tightly_coupled_memory_dec.double ##1 LOAD_ACCESS_FAULT);
  clamp_c: cover property (csr_wr && wr_thr == 5'h1f);
  set_wins_c: cover property (csr_wr && ic_err);
endmodule // mect_top

// ==== tb/mect_mem_model.sv ====
`timescale 1ns/100ps
module mect_mem_model (
  input wire logic clk,
  output mect_pkg::mect_data_tightly_coupled_memory_req_t dreq,
  output mect_pkg::mect_fetch_t fetch,
  output mect_pkg::mect_sys_t sys
);
  import mect_pkg::*;

  // System memory keeps its own count of corrected words
  localparam int SB_LIMIT = 2;
  int sb_count = 0;
  logic ext_irq = 1'b0;
  // ****
  // Memory side
  // ****
  initial begin
    dreq = '0;
    fetch = '0;
    sys = '0;
  end

  // Check bits at Hamming powers of two, ecc[6] evens the whole word
  function automatic logic [38:0] enc(input logic [31:0] d);
    logic [5:0] c;
    int j;
    c = '0;
    j = 0;
    for (int p = 1; p <= 38; p++) begin
      if ((p & (p - 1)) != 0) begin
        for (int i = 0; i < 6; i++) if (p[i]) c[i] ^= d[j];
        j++;
      end
    end
    return {^{d, c}, c, d};
  endfunction

  task automatic issue(input int tgt, input mect_kind_t k, input logic r, input logic ns,
                       input logic [31:0] d, input int nflip);
    logic [38:0] w;
    w = enc(d) ^ ((nflip == 2) ? 39'h60 : (nflip == 1) ? 39'h20 : 39'h0);
    if (tgt == 0) dreq = '{1'b1, k, r, ns, 16'h0040, w[31:0], w[38:32]};
    else if (tgt == 1) fetch = '{1'b1, 16'h0080, w[31:0], w[38:32]};
    else sys = '{1'b1, k, nflip == 2};
    if (tgt == 2 && nflip == 1) sb_count++;
    ext_irq = (sb_count >= SB_LIMIT);
    @(negedge clk);
    // Released lines carry the inverse word so stale data cannot pass
    dreq = '{1'b0, k, 1'b0, 1'b0, 16'h0, ~w[31:0], ~w[38:32]};
    fetch = '{1'b0, 16'h0, ~w[31:0], ~w[38:32]};
    sys = '0;
  endtask
endmodule // mect_mem_model

// ==== tb/mect_top_tb.sv ====
`timescale 1ns/100ps
module mect_top_tb;
  import mect_pkg::*;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic ce_en = 1'b0;
  logic hit, ce;
  logic [31:0] rdata, ddata;
  logic [3:0] tag_err = 4'h0;
  logic [3:0] dat_err = 4'h0;
  mect_csr_t csr = '0;
  mect_data_tightly_coupled_memory_req_t dreq;
  mect_fetch_t fetch;
  mect_sys_t sys;
  mect_wb_t dwb, iwb;
  wire [11:0] flags;
  int fails = 0;
  int n_compared = 0;

  always #20 mclk = ~mclk;

  mect_mem_model mem_u (.clk(mclk), .dreq(dreq), .fetch(fetch), .sys(sys));
  mect_top dut_u (.MCLK(mclk), .RST(rst), .CSR(csr), .CSR_HIT(hit), .CSR_RDATA(rdata),
    .DATA_TIGHTLY_COUPLED_MEMORY_REQ(dreq), .DATA_TIGHTLY_COUPLED_MEMORY_DATA(ddata), .DATA_TIGHTLY_COUPLED_MEMORY_DATA_VALID(flags[11]), .DATA_TIGHTLY_COUPLED_MEMORY_WB(dwb),
    .DATA_TIGHTLY_COUPLED_MEMORY_SB_COUNT(flags[9]), .INSTRUCTION_TIGHTLY_COUPLED_MEMORY_FETCH(fetch), .INSTRUCTION_TIGHTLY_COUPLED_MEMORY_WB(iwb), .INSTRUCTION_TIGHTLY_COUPLED_MEMORY_SB_COUNT(flags[7]),
    .IC_TAG_ERR(tag_err), .IC_DATA_ERR(dat_err), .SYS_RESP(sys), .SYS_DATA_OK(flags[0]),
    .REFETCH_PC_FLUSH(flags[6]), .INSTR_ACCESS_FAULT(flags[5]), .LOAD_ACCESS_FAULT(flags[4]),
    .STORE_ACCESS_FAULT(flags[3]), .STORE_BUS_NMI(flags[2]), .DMA_ERR_RESP(flags[1]),
    .CE_INT_EN(ce_en), .CE_INT(ce));
  assign flags[10] = dwb.en;
  assign flags[8] = iwb.en;

  // ****
  // Access and compare tasks
  // ****
  task automatic results;
    $display("compared=%0d fails=%0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [38:0] got, input logic [38:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic csr_wr(input logic [31:0] v);
    csr = '{1'b1, MECT_IC_CNT_ADDR, v};
    @(negedge mclk);
    csr.we = 1'b0;
    @(negedge mclk);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    csr.addr = a;
    #1;
    chk(rdata, exp);
    chk(hit, a == MECT_IC_CNT_ADDR);
    @(negedge mclk);
  endtask

  task automatic ic_err(input logic [3:0] t, input logic [3:0] d, input logic exp_ce);
    tag_err = t;
    dat_err = d;
    @(negedge mclk);
    tag_err = 4'h0;
    dat_err = 4'h0;
    chk(flags[6], 1'b1);
    chk(ce, exp_ce);
    @(negedge mclk);
  endtask

  // Flag order: valid,dwb,dsb,iwb,isb,flush,instr,load,store,nmi,dma,ok
  task automatic op(input int tgt, input mect_kind_t k, input logic r, input logic ns,
                    input int nflip, input logic [11:0] exp);
    logic [31:0] d;
    d = 32'h5a3c0f00 + 32'(tgt * 16 + nflip);
    mem_u.issue(tgt, k, r, ns, d, nflip);
    chk(flags, exp);
    if (exp[11]) chk(ddata, d);
    if (exp[10]) chk({dwb.ecc, dwb.data}, mem_u.enc(d));
    if (exp[10]) chk(dwb.addr, 16'h0040);
    if (exp[8]) chk({iwb.ecc, iwb.data}, mem_u.enc(d));
    if (exp[8]) chk(iwb.addr, 16'h0080);
    @(negedge mclk);
  endtask

  initial begin
    #20000;
    fails++;
    results;
  end

  initial begin
    repeat (2) @(negedge mclk);
    rst = 1'b0;
    @(negedge mclk);
    rd(MECT_IC_CNT_ADDR, 32'h0);
    csr_wr({5'd31, 27'd5});
    rd(MECT_IC_CNT_ADDR, 32'hd0000005);
    rd(MECT_IC_CNT_ADDR, 32'hd0000005);
    rd(12'h7f1, 32'h0);
    csr_wr(32'h08000000);
    ce_en = 1'b1;
    ic_err(4'h1, 4'h0, 1'b0);
    ic_err(4'hf, 4'hf, 1'b1);
    rd(MECT_IC_CNT_ADDR, 32'h08000002);
    ic_err(4'h0, 4'h2, 1'b1);
    ic_err(4'h0, 4'h8, 1'b0);
    rd(MECT_IC_CNT_ADDR, 32'h08000004);
    csr_wr(32'h08000002);
    ce_en = 1'b0;
    @(negedge mclk);
    chk(ce, 1'b0);
    ce_en = 1'b1;
    @(negedge mclk);
    chk(ce, 1'b1);
    csr_wr(32'h08000000);
    chk(ce, 1'b0);
    csr_wr({5'd0, 27'h7ffffff});
    ic_err(4'h2, 4'h0, 1'b0);
    rd(MECT_IC_CNT_ADDR, 32'h0);
    fork
      csr_wr(32'h0);
      ic_err(4'h4, 4'h0, 1'b1);
    join
    rd(MECT_IC_CNT_ADDR, 32'h1);
    op(0, ACC_LOAD, 1'b1, 1'b1, 1, 12'he00);
    op(0, ACC_LOAD, 1'b0, 1'b0, 1, 12'h800);
    op(0, ACC_STORE, 1'b1, 1'b1, 1, 12'he00);
    op(0, ACC_DMA, 1'b0, 1'b0, 1, 12'he00);
    op(0, ACC_LOAD, 1'b0, 1'b1, 2, 12'h010);
    op(0, ACC_LOAD, 1'b0, 1'b0, 2, 12'h000);
    op(0, ACC_STORE, 1'b0, 1'b0, 2, 12'h000);
    op(0, ACC_STORE, 1'b0, 1'b1, 2, 12'h008);
    op(0, ACC_DMA, 1'b0, 1'b0, 2, 12'h002);
    op(1, ACC_FETCH, 1'b0, 1'b0, 1, 12'h1c0);
    op(2, ACC_FETCH, 1'b0, 1'b0, 2, 12'h020);
    op(2, ACC_LOAD, 1'b0, 1'b0, 2, 12'h010);
    op(2, ACC_STORE, 1'b0, 1'b0, 2, 12'h004);
    op(2, ACC_LOAD, 1'b0, 1'b0, 1, 12'h001);
    chk(mem_u.ext_irq, 1'b0);
    op(2, ACC_FETCH, 1'b0, 1'b0, 1, 12'h001);
    chk(mem_u.ext_irq, 1'b1);
    results;
  end
endmodule // mect_top_tb
